// file: pkg/scb_pkg.sv
`default_nettype none
package scb_pkg;
	// register byte offsets
	localparam logic [11:0] SCB_MAC_OFF = 12'h248;
	localparam logic [11:0] SCB_DDR_OFF = 12'h24c;
	localparam logic [11:0] SCB_DLY_OFF = 12'h250;
	localparam logic [11:0] SCB_MON_OFF = 12'h254;
	localparam logic [11:0] SCB_HST_OFF = 12'h258;
	localparam logic [11:0] SCB_DSP_OFF = 12'h25c;
	localparam logic [11:0] SCB_LVD_OFF = 12'h260;
	// writable bits of each register except MON and HST, which the regbank writes with 16'hffff
	localparam logic [15:0] SCB_MAC_WMASK = 16'h7fe0;
	localparam logic [15:0] SCB_DDR_WMASK = 16'h3fc3;
	localparam logic [15:0] SCB_DLY_WMASK = 16'hffff;
	localparam logic [15:0] SCB_DSP_WMASK = 16'hffff;
	localparam logic [15:0] SCB_LVD_WMASK = 16'hbfff;
	// reset values
	localparam logic [15:0] SCB_MAC_RST = 16'h4040;
	localparam logic [15:0] SCB_DDR_RST = 16'h0002;
	localparam logic [15:0] SCB_DLY_RST = 16'h0810;
	localparam logic [15:0] SCB_MON_RST = 16'h0607;
	localparam logic [15:0] SCB_HST_RST = 16'h8c87;
	localparam logic [15:0] SCB_DSP_RST = 16'h8000;
	localparam logic [15:0] SCB_LVD_RST = 16'h0000;
	// field positions
	localparam int SCB_MAC_FLOW_BIT = 9;
	localparam int SCB_MAC_REMAP_BIT = 5;
	localparam int SCB_DDR_ODT1_BIT = 13;
	localparam int SCB_DDR_BST1_BIT = 12;
	localparam int SCB_DDR_LP1_BIT = 11;
	localparam int SCB_DDR_ODT0_BIT = 10;
	localparam int SCB_DDR_BST0_BIT = 9;
	localparam int SCB_DDR_LP0_BIT = 8;
	localparam int SCB_DDR_POC_BIT = 7;
	localparam int SCB_DDR_SIM_BIT = 6;
	localparam int SCB_DDR_SPDIF_BIT = 1;
	localparam int SCB_DLY_RXEN_BIT = 15;
	localparam int SCB_DLY_TXEN_BIT = 14;
	localparam int SCB_DLY_RX_LSB = 7;
	localparam int SCB_DLY_TX_LSB = 0;
	localparam int SCB_MON_ST1_BIT = 15;
	localparam int SCB_MON_ST0_BIT = 14;
	localparam int SCB_MON_MOB_BIT = 13;
	localparam int SCB_HST_MUX_BIT = 15;
	localparam int SCB_HST_FREQ_LSB = 3;
	localparam int SCB_DSP_TBUS_BIT = 14;
	localparam int SCB_DSP_ADC_BIT = 13;
	localparam int SCB_DSP_REF_BIT = 12;
	localparam int SCB_DSP_DSI1_BIT = 9;
	localparam int SCB_DSP_DSI0_BIT = 6;
	localparam int SCB_DSP_EDP_BIT = 5;
	localparam int SCB_DSP_MMP_BIT = 4;
	localparam int SCB_DSP_LVDS_BIT = 3;
	localparam int SCB_DSP_IEP_BIT = 2;
	localparam int SCB_DSP_CAM_BIT = 1;
	localparam int SCB_LVD_PD_BIT = 15;
	localparam int SCB_LVD_TRACE_BIT = 13;
endpackage : scb_pkg
`default_nettype wire

// file: rtl/scb_regbank.sv
// What this block does
// R1: upper half masks which lower bits update
// R2: flow-control bit drives MAC pause/back-pressure
// R3: per-channel termination enable bits 13,10
// R4: per-channel burst-stop disable bits 12,9
// R5: low-power memory mode bits 11,8
// R6: flash voltage source selects gpio or vsel
// R7: SIM mux bit routes pin sets
// R8: delay-line enables bits 15,14 reset zero
// R9: seven-bit delay values reset to 0x10
// R10: monitor statistics enables bits 15,14
// R11: monitor memory type bit 13
// R12: host sideband fields drive host inputs
// R13: host mux bit resets to one
// R14: host remap bit 5, bits 4:0 zero
// R15: test-bus source select bit 14
// R16: ADC clock pin select bit 13
// R17: reference clock pin select bit 12
// R18: display sinks choose secondary or primary output
// R19: image enhancer output select bit 2
// R20: camera PHY select bit 1
// R21: LVDS power-down bit 15 resets zero
// R22: LVDS pins as trace bus bit 13
// R23: mask half and reserved bits read zero
// R24: outputs follow stored fields continuously
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module scb_regbank (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic flash_gpio_pin,
	output logic [15:0] mac_ctrl,
	output logic mac_flow_control,
	output logic host_remap,
	output logic ch1_termination_enable,
	output logic ch0_termination_enable,
	output logic ch1_burst_stop_disable,
	output logic ch0_burst_stop_disable,
	output logic ch1_low_power_memory_mode,
	output logic ch0_low_power_memory_mode,
	output logic flash_io_voltage_source,
	output logic flash_io_1v8,
	output logic sim_mux_select,
	output logic digital_audio_two_channel,
	output logic [15:0] pinmux_ctrl,
	output logic rx_delay_enable,
	output logic tx_delay_enable,
	output logic [6:0] rx_delay_amount,
	output logic [6:0] tx_delay_amount,
	output logic ch1_monitor_stats_on,
	output logic ch0_monitor_stats_on,
	output logic monitor_mobile_memory,
	output logic [12:0] host_sideband,
	output logic host_port_mux,
	output logic [9:0] host_freq_reset_value,
	output logic [15:0] host_clock_ctrl,
	output logic test_bus_from_csi,
	output logic adc_clock_pin_select,
	output logic video_ref_clock_pin_select,
	output logic serial_display1_source,
	output logic serial_display0_source,
	output logic edp_source,
	output logic media_port_source,
	output logic lvds_source,
	output logic enhancer_source,
	output logic camera_phy_select,
	output logic [15:0] display_ctrl,
	output logic lvds_power_down,
	output logic lvds_trace_bus,
	output logic [15:0] lvds_ctrl
);
	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	logic wr_pend_reg;
	logic [11:0] wr_addr_reg;
	logic [15:0] mac_reg;
	logic [15:0] ddr_reg;
	logic [15:0] dly_reg;
	logic [15:0] mon_reg;
	logic [15:0] hst_reg;
	logic [15:0] dsp_reg;
	logic [15:0] lvd_reg;
	logic [1:0] gpio_sync_reg;
	logic [15:0] mac_next;
	logic [15:0] ddr_next;
	logic [15:0] dly_next;
	logic [15:0] mon_next;
	logic [15:0] hst_next;
	logic [15:0] dsp_next;
	logic [15:0] lvd_next;
	logic addr_ok;
	logic [31:0] rd_word;
	logic flash_v_next;

	// masked merge: lower bit n updates only if bit n+16 is set
	// reserved bits carry a zero mask, so software can never set them
	function automatic logic [15:0] scb_merge(input logic [15:0] old, input logic [31:0] wd,
		input logic [15:0] wmask);
		scb_merge = (old & ~(wd[31:16] & wmask)) | (wd[15:0] & wd[31:16] & wmask); // [R1]
	endfunction : scb_merge

	// any aligned word outside the map reads zero, writes drop
	// upper address bits are not decoded, so the bank repeats every 4 KB
	function automatic logic scb_mapped(input logic [11:0] a);
		scb_mapped = (a >= scb_pkg::SCB_MAC_OFF) && (a <= scb_pkg::SCB_LVD_OFF) && (a[1:0] == 2'b00);
	endfunction : scb_mapped

	// zero wait states: ready from the first edge after reset
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			hreadyout <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
		end
	end

	// no error case exists, so the response is always OKAY
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	// capture write address phase
	// htrans bit 1 covers NONSEQ and SEQ; IDLE and BUSY are ignored
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 12'h000;
		end else if (hready) begin
			wr_pend_reg <= hsel && htrans[1] && hwrite;
			wr_addr_reg <= haddr[11:0];
		end
	end

	// read data: upper half and reserved bits are zero
	// reads the next values, so a read right behind a write sees the new word
	always_comb begin
		addr_ok = scb_mapped(haddr[11:0]);
		rd_word = 32'h0000_0000; // [R23]
		if (addr_ok) begin
			case (haddr[11:0])
				scb_pkg::SCB_MAC_OFF: rd_word = {16'h0000, mac_next};
				scb_pkg::SCB_DDR_OFF: rd_word = {16'h0000, ddr_next};
				scb_pkg::SCB_DLY_OFF: rd_word = {16'h0000, dly_next};
				scb_pkg::SCB_MON_OFF: rd_word = {16'h0000, mon_next};
				scb_pkg::SCB_HST_OFF: rd_word = {16'h0000, hst_next};
				scb_pkg::SCB_DSP_OFF: rd_word = {16'h0000, dsp_next};
				scb_pkg::SCB_LVD_OFF: rd_word = {16'h0000, lvd_next};
				default: rd_word = 32'h0000_0000;
			endcase
		end
	end

	// read data registered at address phase, stands through data phase
	// it then holds until the next read, so a late sampler still sees it
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			hrdata <= rd_word;
		end
	end

	// ------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------
	// next values; reserved bits masked off so they stay zero
	// one write per data phase, so at most one register changes per cycle
	always_comb begin
		mac_next = mac_reg;
		ddr_next = ddr_reg;
		dly_next = dly_reg;
		mon_next = mon_reg;
		hst_next = hst_reg;
		dsp_next = dsp_reg;
		lvd_next = lvd_reg;
		if (wr_pend_reg) begin
			case (wr_addr_reg)
				scb_pkg::SCB_MAC_OFF: mac_next = scb_merge(mac_reg, hwdata, scb_pkg::SCB_MAC_WMASK); // [R14]
				scb_pkg::SCB_DDR_OFF: ddr_next = scb_merge(ddr_reg, hwdata, scb_pkg::SCB_DDR_WMASK);
				scb_pkg::SCB_DLY_OFF: dly_next = scb_merge(dly_reg, hwdata, scb_pkg::SCB_DLY_WMASK);
				scb_pkg::SCB_MON_OFF: mon_next = scb_merge(mon_reg, hwdata, 16'hffff);
				scb_pkg::SCB_HST_OFF: hst_next = scb_merge(hst_reg, hwdata, 16'hffff);
				scb_pkg::SCB_DSP_OFF: dsp_next = scb_merge(dsp_reg, hwdata, scb_pkg::SCB_DSP_WMASK);
				scb_pkg::SCB_LVD_OFF: lvd_next = scb_merge(lvd_reg, hwdata, scb_pkg::SCB_LVD_WMASK);
				default: mac_next = mac_reg;
			endcase
		end
	end

	// stored values; new value visible at the edge that ends the data phase
	// async reset loads the power-on values of every field
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			mac_reg <= scb_pkg::SCB_MAC_RST;
			ddr_reg <= scb_pkg::SCB_DDR_RST;
			dly_reg <= scb_pkg::SCB_DLY_RST; // [R8] [R9]
			mon_reg <= scb_pkg::SCB_MON_RST;
			hst_reg <= scb_pkg::SCB_HST_RST; // [R13]
			dsp_reg <= scb_pkg::SCB_DSP_RST;
			lvd_reg <= scb_pkg::SCB_LVD_RST; // [R21]
		end else begin
			mac_reg <= mac_next; // [R24]
			ddr_reg <= ddr_next;
			dly_reg <= dly_next;
			mon_reg <= mon_next;
			hst_reg <= hst_next;
			dsp_reg <= dsp_next;
			lvd_reg <= lvd_next;
		end
	end

	// pin synchroniser; stage 0 only feeds stage 1
	// the pin is asynchronous, so only the second stage is read by logic
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			gpio_sync_reg <= 2'b00;
		end else begin
			gpio_sync_reg <= {gpio_sync_reg[0], flash_gpio_pin};
		end
	end

	// ------------------------------------------------------------
	// outputs, registered from next values so they track the store
	// ------------------------------------------------------------
	// flash domain: gpio level or vsel bit 2 of the mac register
	always_comb begin
		if (ddr_next[scb_pkg::SCB_DDR_POC_BIT]) begin
			flash_v_next = mac_next[2]; // [R6]
		end else begin
			flash_v_next = gpio_sync_reg[1]; // [R6]
		end
	end

	// mac control outputs; the flow bit is a level, the mac itself sends pause frames
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			mac_ctrl <= scb_pkg::SCB_MAC_RST;
			mac_flow_control <= scb_pkg::SCB_MAC_RST[scb_pkg::SCB_MAC_FLOW_BIT];
			host_remap <= scb_pkg::SCB_MAC_RST[scb_pkg::SCB_MAC_REMAP_BIT];
		end else begin
			mac_ctrl <= mac_next;
			mac_flow_control <= mac_next[scb_pkg::SCB_MAC_FLOW_BIT]; // [R2]
			host_remap <= mac_next[scb_pkg::SCB_MAC_REMAP_BIT]; // [R14]
		end
	end

	// ddr mode and pinmux outputs
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ch1_termination_enable <= 1'b0;
			ch0_termination_enable <= 1'b0;
			ch1_burst_stop_disable <= 1'b0;
			ch0_burst_stop_disable <= 1'b0;
			ch1_low_power_memory_mode <= 1'b0;
			ch0_low_power_memory_mode <= 1'b0;
			flash_io_voltage_source <= 1'b0;
			flash_io_1v8 <= 1'b0;
			sim_mux_select <= 1'b0;
			digital_audio_two_channel <= scb_pkg::SCB_DDR_RST[scb_pkg::SCB_DDR_SPDIF_BIT];
			pinmux_ctrl <= scb_pkg::SCB_DDR_RST;
		end else begin
			ch1_termination_enable <= ddr_next[scb_pkg::SCB_DDR_ODT1_BIT]; // [R3]
			ch0_termination_enable <= ddr_next[scb_pkg::SCB_DDR_ODT0_BIT]; // [R3]
			ch1_burst_stop_disable <= ddr_next[scb_pkg::SCB_DDR_BST1_BIT]; // [R4]
			ch0_burst_stop_disable <= ddr_next[scb_pkg::SCB_DDR_BST0_BIT]; // [R4]
			ch1_low_power_memory_mode <= ddr_next[scb_pkg::SCB_DDR_LP1_BIT]; // [R5]
			ch0_low_power_memory_mode <= ddr_next[scb_pkg::SCB_DDR_LP0_BIT]; // [R5]
			flash_io_voltage_source <= ddr_next[scb_pkg::SCB_DDR_POC_BIT];
			flash_io_1v8 <= flash_v_next; // [R6]
			sim_mux_select <= ddr_next[scb_pkg::SCB_DDR_SIM_BIT]; // [R7]
			digital_audio_two_channel <= ddr_next[scb_pkg::SCB_DDR_SPDIF_BIT];
			pinmux_ctrl <= ddr_next;
		end
	end

	// delay-line outputs; lines start disabled with an amount of 0x10
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rx_delay_enable <= scb_pkg::SCB_DLY_RST[scb_pkg::SCB_DLY_RXEN_BIT];
			tx_delay_enable <= scb_pkg::SCB_DLY_RST[scb_pkg::SCB_DLY_TXEN_BIT];
			rx_delay_amount <= scb_pkg::SCB_DLY_RST[scb_pkg::SCB_DLY_RX_LSB +: 7];
			tx_delay_amount <= scb_pkg::SCB_DLY_RST[scb_pkg::SCB_DLY_TX_LSB +: 7];
		end else begin
			rx_delay_enable <= dly_next[scb_pkg::SCB_DLY_RXEN_BIT]; // [R8]
			tx_delay_enable <= dly_next[scb_pkg::SCB_DLY_TXEN_BIT]; // [R8]
			rx_delay_amount <= dly_next[scb_pkg::SCB_DLY_RX_LSB +: 7]; // [R9]
			tx_delay_amount <= dly_next[scb_pkg::SCB_DLY_TX_LSB +: 7]; // [R9]
		end
	end

	// ddr monitor and host sideband outputs
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ch1_monitor_stats_on <= scb_pkg::SCB_MON_RST[scb_pkg::SCB_MON_ST1_BIT];
			ch0_monitor_stats_on <= scb_pkg::SCB_MON_RST[scb_pkg::SCB_MON_ST0_BIT];
			monitor_mobile_memory <= scb_pkg::SCB_MON_RST[scb_pkg::SCB_MON_MOB_BIT];
			host_sideband <= scb_pkg::SCB_MON_RST[12:0];
		end else begin
			ch1_monitor_stats_on <= mon_next[scb_pkg::SCB_MON_ST1_BIT]; // [R10]
			ch0_monitor_stats_on <= mon_next[scb_pkg::SCB_MON_ST0_BIT]; // [R10]
			monitor_mobile_memory <= mon_next[scb_pkg::SCB_MON_MOB_BIT]; // [R11]
			host_sideband <= mon_next[12:0]; // [R12]
		end
	end

	// host port outputs; the mux resets to 8-bit in, 16-bit out
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			host_port_mux <= scb_pkg::SCB_HST_RST[scb_pkg::SCB_HST_MUX_BIT];
			host_freq_reset_value <= scb_pkg::SCB_HST_RST[scb_pkg::SCB_HST_FREQ_LSB +: 10];
			host_clock_ctrl <= scb_pkg::SCB_HST_RST;
		end else begin
			host_port_mux <= hst_next[scb_pkg::SCB_HST_MUX_BIT]; // [R13]
			host_freq_reset_value <= hst_next[scb_pkg::SCB_HST_FREQ_LSB +: 10]; // [R12]
			host_clock_ctrl <= hst_next;
		end
	end

	// display routing outputs
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			test_bus_from_csi <= 1'b0;
			adc_clock_pin_select <= 1'b0;
			video_ref_clock_pin_select <= 1'b0;
			serial_display1_source <= 1'b0;
			serial_display0_source <= 1'b0;
			edp_source <= 1'b0;
			media_port_source <= 1'b0;
			lvds_source <= 1'b0;
			enhancer_source <= 1'b0;
			camera_phy_select <= 1'b0;
			display_ctrl <= scb_pkg::SCB_DSP_RST;
		end else begin
			test_bus_from_csi <= dsp_next[scb_pkg::SCB_DSP_TBUS_BIT]; // [R15]
			adc_clock_pin_select <= dsp_next[scb_pkg::SCB_DSP_ADC_BIT]; // [R16]
			video_ref_clock_pin_select <= dsp_next[scb_pkg::SCB_DSP_REF_BIT]; // [R17]
			serial_display1_source <= dsp_next[scb_pkg::SCB_DSP_DSI1_BIT]; // [R18]
			serial_display0_source <= dsp_next[scb_pkg::SCB_DSP_DSI0_BIT]; // [R18]
			edp_source <= dsp_next[scb_pkg::SCB_DSP_EDP_BIT]; // [R18]
			media_port_source <= dsp_next[scb_pkg::SCB_DSP_MMP_BIT]; // [R18]
			lvds_source <= dsp_next[scb_pkg::SCB_DSP_LVDS_BIT]; // [R18]
			enhancer_source <= dsp_next[scb_pkg::SCB_DSP_IEP_BIT]; // [R19]
			camera_phy_select <= dsp_next[scb_pkg::SCB_DSP_CAM_BIT]; // [R20]
			display_ctrl <= dsp_next;
		end
	end

	// lvds phy outputs; power-down resets low so the phy comes up powered
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			lvds_power_down <= scb_pkg::SCB_LVD_RST[scb_pkg::SCB_LVD_PD_BIT];
			lvds_trace_bus <= scb_pkg::SCB_LVD_RST[scb_pkg::SCB_LVD_TRACE_BIT];
			lvds_ctrl <= scb_pkg::SCB_LVD_RST;
		end else begin
			lvds_power_down <= lvd_next[scb_pkg::SCB_LVD_PD_BIT]; // [R21]
			lvds_trace_bus <= lvd_next[scb_pkg::SCB_LVD_TRACE_BIT]; // [R22]
			lvds_ctrl <= lvd_next;
		end
	end
endmodule : scb_regbank
`default_nettype wire

// file: tb/scb_regbank_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module scb_regbank_assertions (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] haddr,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic [15:0] mac_ctrl,
	input wire logic mac_flow_control,
	input wire logic host_remap,
	input wire logic [15:0] pinmux_ctrl,
	input wire logic ch1_termination_enable,
	input wire logic ch0_low_power_memory_mode,
	input wire logic flash_io_voltage_source,
	input wire logic flash_io_1v8,
	input wire logic rx_delay_enable,
	input wire logic [6:0] tx_delay_amount,
	input wire logic [15:0] display_ctrl,
	input wire logic lvds_source,
	input wire logic camera_phy_select,
	input wire logic lvds_power_down
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// ----
	// data phase tracking
	// ----
	logic wr_dp;
	logic rd_dp;
	logic [11:0] dp_addr;
	// zero-wait slave, so the data phase is always the very next cycle
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wr_dp <= 1'b0;
			rd_dp <= 1'b0;
			dp_addr <= 12'h000;
		end else begin
			wr_dp <= hsel && htrans[1] && hready && hwrite;
			rd_dp <= hsel && htrans[1] && hready && !hwrite;
			dp_addr <= haddr[11:0];
		end
	end
	// ----
	// properties
	// ----
	ready_always_a: assert property ($past(nrst) |-> hreadyout) else $error("hreadyout low");
	okay_resp_a: assert property (hresp == 1'b0) else $error("hresp not okay");
	mask_hold_a: assert property (!$stable(lvds_power_down) |->
		$past(wr_dp && dp_addr == scb_pkg::SCB_LVD_OFF && hwdata[31])) else $error("unmasked change");
	delay_write_a: assert property (wr_dp && dp_addr == scb_pkg::SCB_DLY_OFF && &hwdata[22:16] |=>
		tx_delay_amount == $past(hwdata[6:0])) else $error("tx delay not written");
	rx_enable_a: assert property (wr_dp && dp_addr == scb_pkg::SCB_DLY_OFF && hwdata[31] |=>
		rx_delay_enable == $past(hwdata[15])) else $error("rx enable not written");
	flow_bit_a: assert property (wr_dp && dp_addr == scb_pkg::SCB_MAC_OFF && hwdata[25] |=>
		mac_flow_control == $past(hwdata[9]) && mac_ctrl[9] == mac_flow_control) else $error("flow bit");
	remap_bit_a: assert property (host_remap == mac_ctrl[5] && mac_ctrl[4:0] == 5'h00) else $error("remap");
	ddr_bits_a: assert property (ch1_termination_enable == pinmux_ctrl[13] &&
		ch0_low_power_memory_mode == pinmux_ctrl[8]) else $error("ddr bits");
	flash_sel_a: assert property (flash_io_voltage_source && $past(flash_io_voltage_source) |->
		flash_io_1v8 == mac_ctrl[2]) else $error("flash select");
	display_sel_a: assert property (wr_dp && dp_addr == scb_pkg::SCB_DSP_OFF && &hwdata[19:17] |=>
		lvds_source == $past(hwdata[3]) && camera_phy_select == $past(hwdata[1])) else $error("display select");
	read_upper_a: assert property (rd_dp |-> hrdata[31:16] == 16'h0000) else $error("upper half");
	// ----
	// coverage
	// ----
	lvds_write_c: cover property (wr_dp && dp_addr == scb_pkg::SCB_LVD_OFF);
	read_c: cover property (rd_dp);
	flash_src_c: cover property (flash_io_voltage_source);
endmodule : scb_regbank_assertions
bind scb_regbank scb_regbank_assertions u_chk (.*);
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	// ----
	// signals
	// ----
	logic core_clk, nrst, hsel, hwrite, flash_gpio_pin, rd_dp;
	logic [31:0] haddr, hwdata, hrdata, d;
	logic [1:0] htrans;
	logic [2:0] hsize;
	wire logic hready;
	logic hreadyout, hresp, mac_flow_control, host_remap, ch1_termination_enable, ch0_termination_enable;
	logic ch1_burst_stop_disable, ch0_burst_stop_disable, ch1_low_power_memory_mode, ch0_low_power_memory_mode;
	logic flash_io_voltage_source, flash_io_1v8, sim_mux_select, digital_audio_two_channel;
	logic rx_delay_enable, tx_delay_enable, ch1_monitor_stats_on, ch0_monitor_stats_on, monitor_mobile_memory;
	logic host_port_mux, test_bus_from_csi, adc_clock_pin_select, video_ref_clock_pin_select;
	logic serial_display1_source, serial_display0_source, edp_source, media_port_source, lvds_source;
	logic enhancer_source, camera_phy_select, lvds_power_down, lvds_trace_bus;
	logic [15:0] mac_ctrl, pinmux_ctrl, host_clock_ctrl, display_ctrl, lvds_ctrl;
	logic [6:0] rx_delay_amount, tx_delay_amount;
	logic [12:0] host_sideband;
	logic [9:0] host_freq_reset_value;
	int miscompares, tests_run, seed, k;
	logic [31:0] exp_q[$];
	logic [15:0] m[8], wm[8];
	logic [11:0] off[8];
	assign hready = hreadyout; // single slave drives the bus ready
	scb_regbank dut (.*);
	// clock
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	// ----
	// tasks
	// ----
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : summarize
	// one single transfer; holds each phase until hready is seen high
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {20'h00000, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge core_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge core_clk); while (hready !== 1'b1);
	endtask : xfer
	task automatic rd(input int i);
		exp_q.push_back({16'h0000, m[i]});
		xfer(1'b0, off[i], 32'h00000000);
	endtask : rd
	task automatic ports;
		logic fl;
		fl = m[1][7] ? m[0][2] : flash_gpio_pin;
		chk("mac", {m[0][9], m[0][5], m[0]}, {mac_flow_control, host_remap, mac_ctrl});
		chk("ddr", {m[1][13:6], m[1][1], fl, m[1]}, {ch1_termination_enable, ch1_burst_stop_disable,
			ch1_low_power_memory_mode, ch0_termination_enable, ch0_burst_stop_disable, ch0_low_power_memory_mode,
			flash_io_voltage_source, sim_mux_select, digital_audio_two_channel, flash_io_1v8, pinmux_ctrl});
		chk("dly", m[2], {rx_delay_enable, tx_delay_enable, rx_delay_amount, tx_delay_amount});
		chk("mon", m[3], {ch1_monitor_stats_on, ch0_monitor_stats_on, monitor_mobile_memory, host_sideband});
		chk("hst", {m[4], m[4][15], m[4][12:3]}, {host_clock_ctrl, host_port_mux, host_freq_reset_value});
		chk("dsp", {m[5][14:12], m[5][9], m[5][6:1], m[5]}, {test_bus_from_csi, adc_clock_pin_select,
			video_ref_clock_pin_select, serial_display1_source, serial_display0_source, edp_source,
			media_port_source, lvds_source, enhancer_source, camera_phy_select, display_ctrl});
		chk("lvd", {m[6][15], m[6][13], m[6]}, {lvds_power_down, lvds_trace_bus, lvds_ctrl});
	endtask : ports
	// ----
	// read-data monitor: oldest note against each completed read
	// ----
	always @(posedge core_clk) begin
		if (rd_dp === 1'b1 && hready === 1'b1) begin
			chk("hrdata", exp_q.pop_front(), hrdata);
			chk("hresp", 32'h00000000, {31'h00000000, hresp});
		end
		rd_dp <= nrst && hsel && htrans[1] && hready && !hwrite;
	end
	// watchdog, far beyond the few hundred cycles the sequence needs
	initial begin
		repeat (20000) @(posedge core_clk);
		miscompares++;
		summarize();
	end
	// ----
	// main sequence
	// ----
	initial begin
		seed = 1;
		nrst = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h00000000;
		flash_gpio_pin = 1'b0;
		off = '{scb_pkg::SCB_MAC_OFF, scb_pkg::SCB_DDR_OFF, scb_pkg::SCB_DLY_OFF, scb_pkg::SCB_MON_OFF,
			scb_pkg::SCB_HST_OFF, scb_pkg::SCB_DSP_OFF, scb_pkg::SCB_LVD_OFF, 12'h264};
		wm = '{scb_pkg::SCB_MAC_WMASK, scb_pkg::SCB_DDR_WMASK, scb_pkg::SCB_DLY_WMASK, 16'hffff,
			16'hffff, scb_pkg::SCB_DSP_WMASK, scb_pkg::SCB_LVD_WMASK, 16'h0000};
		m = '{scb_pkg::SCB_MAC_RST, scb_pkg::SCB_DDR_RST, scb_pkg::SCB_DLY_RST, scb_pkg::SCB_MON_RST,
			scb_pkg::SCB_HST_RST, scb_pkg::SCB_DSP_RST, scb_pkg::SCB_LVD_RST, 16'h0000};
		repeat (10) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk("rst", {7'h10, 7'h10, 10'h190, 3'b100}, {rx_delay_amount, tx_delay_amount,
			host_freq_reset_value, host_port_mux, rx_delay_enable, lvds_power_down});
		for (int i = 0; i < 8; i++) begin
			rd(i);
		end
		// random masked writes, a quarter with an empty mask, the unmapped slot among them
		for (int i = 0; i < 80; i++) begin
			k = $random(seed) & 7;
			d = $random(seed);
			if (i % 4 == 0) d[31:16] = 16'h0000;
			flash_gpio_pin <= d[4];
			m[k] = (m[k] & ~(d[31:16] & wm[k])) | (d[15:0] & d[31:16] & wm[k]);
			xfer(1'b1, off[k], d);
			rd(k);
			ports();
		end
		summarize();
	end
endmodule : testbench
`default_nettype wire
